// >>> verilog/fld_leaf_decoder.sv
// top: avalon slave wrapping the 1-GByte first-level leaf decoder
`timescale 1ns/1ps
module fld_leaf_decoder
  import fld_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = 48
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // interrupt
  output logic             irq_o,
  // decode outcome
  output logic             busy_o,
  output logic             granted_o
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [63:0] entry_reg;
  logic [3:0]  req_reg;
  fld_res_t    res_reg;
  logic [63:0] addr_reg;
  logic [63:0] upd_reg;
  fld_state_t  state_reg;
  logic        ack_reg;

  fld_ctl_t    ctl;
  fld_req_t    req;
  fld_res_t    res_c;
  logic [63:0] addr_c;
  logic [63:0] upd_c;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_event;
  logic        irq_line;
  logic        acc;
  logic        wr_hit;
  logic [3:0]  widx;
  logic [31:0] wmask;
  logic [31:0] rd_c;

  assign acc    = (avs_read_i || avs_write_i) && !ack_reg;
  assign wr_hit = avs_write_i && !ack_reg;
  assign widx   = fld_word(avs_address_i);
  assign wmask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // context from the control register
  assign ctl.no_exec_enable          = ctrl_reg[CTL_NO_EXEC];
  assign ctl.write_protect_enable    = ctrl_reg[CTL_WR_PROT];
  assign ctl.ext_accessed_enable     = ctrl_reg[CTL_EXT_ACC];
  assign ctl.first_lvl_huge_page_cap = ctrl_reg[CTL_CAP];
  assign ctl.pasid_xlate_type        = ctrl_reg[CTL_TT_LO +: 3];
  assign req                         = fld_req_t'(req_reg);

  // ****************************************
  // decode core
  // ****************************************
  fld_leaf_check #(
    .HOST_ADDR_WIDTH (HOST_ADDR_WIDTH)
  ) u_check (
    .entry_i     (entry_reg),
    .ctl_i       (ctl),
    .req_i       (req),
    .res_o       (res_c),
    .page_addr_o (addr_c),
    .updated_o   (upd_c)
  );

  // ****************************************
  // bus slave
  // ****************************************
  // one wait cycle per access: waitrequest drops the cycle after the request
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !acc;
    end
  end

  // control register; go bit is self-clearing, ignored while busy
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_hit && widx == REG_CTRL && state_reg == ST_IDLE) begin
      ctrl_reg <= (ctrl_reg & ~wmask) | (avs_writedata_i & wmask);
    end else begin
      ctrl_reg[CTL_GO] <= 1'b0;
    end
  end

  // entry and request registers, frozen while a decode runs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      entry_reg <= '0;
      req_reg   <= '0;
    end else if (wr_hit && state_reg == ST_IDLE) begin
      if (widx == REG_ENT_LO) begin
        entry_reg[31:0] <= (entry_reg[31:0] & ~wmask) | (avs_writedata_i & wmask);
      end
      if (widx == REG_ENT_HI) begin
        entry_reg[63:32] <= (entry_reg[63:32] & ~wmask) | (avs_writedata_i & wmask);
      end
      if (widx == REG_REQ && avs_byteenable_i[0]) begin
        req_reg <= avs_writedata_i[3:0];
      end
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_c = 32'h0000_0000;
    unique case (widx)
      REG_CTRL:    rd_c = ctrl_reg;
      REG_ENT_LO:  rd_c = entry_reg[31:0];
      REG_ENT_HI:  rd_c = entry_reg[63:32];
      REG_REQ:     rd_c = {28'h0000000, req_reg};
      REG_RES:     rd_c = {17'h00000, state_reg != ST_IDLE, res_reg};
      REG_ADDR_LO: rd_c = addr_reg[31:0];
      REG_ADDR_HI: rd_c = addr_reg[63:32];
      REG_UPD_LO:  rd_c = upd_reg[31:0];
      REG_UPD_HI:  rd_c = upd_reg[63:32];
      REG_IRQ_ST:  rd_c = {29'h00000000, irq_status};
      REG_IRQ_MSK: rd_c = {29'h00000000, irq_mask};
      default:     rd_c = 32'h0000_0000;
    endcase
  end

  // read data registered, valid in the answer cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
      avs_readdata_o <= rd_c;
    end
  end

  // ****************************************
  // decode sequencer
  // ****************************************
  // idle -> decode (one cycle to settle the captured entry) -> done
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:   if (ctrl_reg[CTL_GO]) state_reg <= ST_DECODE;
        ST_DECODE: state_reg <= ST_DONE;
        ST_DONE:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // results captured at the end of decode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      res_reg  <= '0;
      addr_reg <= '0;
      upd_reg  <= '0;
    end else if (state_reg == ST_DECODE) begin
      res_reg  <= res_c;
      addr_reg <= addr_c;
      upd_reg  <= upd_c;
    end
  end

  // status outputs straight from flops
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      busy_o    <= 1'b0;
      granted_o <= 1'b0;
    end else begin
      busy_o <= (state_reg == ST_IDLE) ? ctrl_reg[CTL_GO] : (state_reg == ST_DECODE);
      if (state_reg == ST_DECODE) begin
        granted_o <= res_c.granted;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // events: done, absent or reserved fault or any denied non-directory entry, nested (guest-physical) result
  assign irq_event[IRQ_DONE]  = (state_reg == ST_DONE);
  assign irq_event[IRQ_FAULT] = (state_reg == ST_DONE) && (res_reg.fault_present ||
                                res_reg.fault_reserved || (!res_reg.granted && !res_reg.is_directory));
  assign irq_event[IRQ_NEST]  = (state_reg == ST_DONE) && res_reg.guest_phys_addr;

  fld_irq #(
    .N (3)
  ) u_irq (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .event_i  (irq_event),
    .clr_wr_i (wr_hit && widx == REG_IRQ_ST),
    .clr_i    (avs_writedata_i[2:0]),
    .msk_wr_i (wr_hit && widx == REG_IRQ_MSK),
    .msk_i    (avs_writedata_i[2:0]),
    .status_o (irq_status),
    .mask_o   (irq_mask),
    .irq_o    (irq_line)
  );

  assign irq_o = irq_line;

endmodule

// >>> verilog/fld_pkg.sv
// package: entry layout, register map and shared types for the 1-GByte leaf decoder
package fld_pkg;

  // ****************************************
  // entry field positions
  // ****************************************
  localparam int ENT_EXEC_DIS_BIT  = 63;
  localparam int ENT_IGN_HI        = 62;
  localparam int ENT_IGN_LO        = 52;
  localparam int ENT_RSV_HI        = 51;
  localparam int ENT_ADDR_LO       = 30;
  localparam int ENT_RSVL_HI       = 29;
  localparam int ENT_RSVL_LO       = 13;
  localparam int ENT_ATTR_IDX_BIT  = 12;
  localparam int ENT_EXT_ACC_BIT   = 10;
  localparam int ENT_G_BIT         = 8;
  localparam int ENT_SIZE_BIT      = 7;
  localparam int ENT_D_BIT         = 6;
  localparam int ENT_A_BIT         = 5;
  localparam int ENT_CACHE_OFF_BIT = 4;
  localparam int ENT_WR_THRU_BIT   = 3;
  localparam int ENT_US_BIT        = 2;
  localparam int ENT_RW_BIT        = 1;
  localparam int ENT_P_BIT         = 0;
  localparam logic [2:0] XLATE_NESTED = 3'h3;

  // ****************************************
  // register map (word indices, byte address = index*4)
  // ****************************************
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ENT_LO  = 4'h1;
  localparam logic [3:0] REG_ENT_HI  = 4'h2;
  localparam logic [3:0] REG_REQ     = 4'h3;
  localparam logic [3:0] REG_RES     = 4'h4;
  localparam logic [3:0] REG_ADDR_LO = 4'h5;
  localparam logic [3:0] REG_ADDR_HI = 4'h6;
  localparam logic [3:0] REG_UPD_LO  = 4'h7;
  localparam logic [3:0] REG_UPD_HI  = 4'h8;
  localparam logic [3:0] REG_IRQ_ST  = 4'h9;
  localparam logic [3:0] REG_IRQ_MSK = 4'ha;

  // ctrl bits
  localparam int CTL_NO_EXEC = 0;
  localparam int CTL_WR_PROT = 1;
  localparam int CTL_EXT_ACC = 2;
  localparam int CTL_CAP     = 3;
  localparam int CTL_TT_LO   = 4;  // 3-bit translation type at 6:4
  localparam int CTL_GO      = 8;  // write 1: start a decode

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0008;
  localparam logic [2:0]  IRQ_RST   = 3'h0;
  localparam int          DEC_LAT   = 1;  // decode pipeline cycles

  // interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_NEST  = 2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       no_exec_enable;
    logic       write_protect_enable;
    logic       ext_accessed_enable;
    logic       first_lvl_huge_page_cap;
    logic [2:0] pasid_xlate_type;
  } fld_ctl_t;

  typedef struct packed {
    logic is_write;
    logic is_exec;
    logic is_user;
    logic coherent;
  } fld_req_t;

  typedef struct packed {
    logic       fault_present;
    logic       fault_reserved;
    logic       fault_user;
    logic       fault_write;
    logic       fault_exec;
    logic       is_directory;
    logic       guest_phys_addr;
    logic [2:0] mem_type_idx;   // {attr index, cache off, write thru}, zero for non-coherent
    logic       set_accessed;
    logic       set_ext_acc;
    logic       set_dirty;
    logic       granted;
  } fld_res_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DECODE,
    ST_DONE
  } fld_state_t;

  // word select from a byte address
  function automatic logic [3:0] fld_word(input logic [5:0] a);
    return a[5:2];
  endfunction

endpackage

// >>> verilog/fld_leaf_check.sv
// combinational decode and permission check of a 1-GByte leaf entry
`timescale 1ns/1ps
module fld_leaf_check
  import fld_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = 48
) (
  // entry and context
  input  wire logic [63:0] entry_i,
  input  wire fld_ctl_t    ctl_i,
  input  wire fld_req_t    req_i,
  // results
  output fld_res_t         res_o,
  output logic [63:0]      page_addr_o,
  output logic [63:0]      updated_o
);

  logic [63:0] rsv_mask;
  logic        leaf;

  // reserved bits: 51 down to host width and 29..13; bit 7 too without huge-page support
  always_comb begin
    rsv_mask = '0;
    for (int b = HOST_ADDR_WIDTH; b <= ENT_RSV_HI; b++) begin
      rsv_mask[b] = 1'b1;
    end
    for (int b = ENT_RSVL_LO; b <= ENT_RSVL_HI; b++) begin
      rsv_mask[b] = 1'b1;
    end
    if (!ctl_i.first_lvl_huge_page_cap) begin
      rsv_mask[ENT_SIZE_BIT] = 1'b1;
    end
  end

  // leaf only with page size set and support present; bits 62:52, 11, 9, 8 never read
  assign leaf = entry_i[ENT_SIZE_BIT] && ctl_i.first_lvl_huge_page_cap;

  // page frame from host width minus one down to 30, low bits zero
  always_comb begin
    page_addr_o = '0;
    for (int b = ENT_ADDR_LO; b < HOST_ADDR_WIDTH; b++) begin
      page_addr_o[b] = entry_i[b];
    end
  end

  // permission checks
  always_comb begin
    res_o                = '0;
    res_o.fault_present  = !entry_i[ENT_P_BIT];
    res_o.fault_reserved = entry_i[ENT_P_BIT] && |(entry_i & rsv_mask);
    res_o.is_directory   = entry_i[ENT_P_BIT] && !entry_i[ENT_SIZE_BIT] && ctl_i.first_lvl_huge_page_cap;
    res_o.fault_user     = req_i.is_user && !entry_i[ENT_US_BIT];
    res_o.fault_write    = req_i.is_write && !entry_i[ENT_RW_BIT] &&
                           (req_i.is_user || ctl_i.write_protect_enable);
    res_o.fault_exec     = req_i.is_exec && ctl_i.no_exec_enable &&
                           entry_i[ENT_EXEC_DIS_BIT];
    res_o.guest_phys_addr = (ctl_i.pasid_xlate_type == XLATE_NESTED);
    if (req_i.coherent) begin
      res_o.mem_type_idx = {entry_i[ENT_ATTR_IDX_BIT], entry_i[ENT_CACHE_OFF_BIT], entry_i[ENT_WR_THRU_BIT]};
    end
    res_o.granted = 1'b0;
    res_o.set_accessed = 1'b0;
    res_o.set_ext_acc  = 1'b0;
    res_o.set_dirty    = 1'b0;
    if (leaf && !res_o.fault_present && !res_o.fault_reserved) begin
      res_o.granted      = !(res_o.fault_user || res_o.fault_write || res_o.fault_exec);
      res_o.set_accessed = 1'b1;
      res_o.set_ext_acc  = ctl_i.ext_accessed_enable;
      res_o.set_dirty    = res_o.granted && req_i.is_write;
    end
  end

  // entry as written back: accessed, ext-accessed and dirty set as used
  always_comb begin
    updated_o = entry_i;
    if (res_o.set_accessed) begin
      updated_o[ENT_A_BIT] = 1'b1;
    end
    if (res_o.set_ext_acc) begin
      updated_o[ENT_EXT_ACC_BIT] = 1'b1;
    end
    if (res_o.set_dirty) begin
      updated_o[ENT_D_BIT] = 1'b1;
    end
  end

endmodule

// >>> verilog/fld_irq.sv
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module fld_irq
  import fld_pkg::*;
#(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // events and software access
  input  wire logic [N-1:0] event_i,
  input  wire logic         clr_wr_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic         msk_wr_i,
  input  wire logic [N-1:0] msk_i,
  // state
  output logic [N-1:0]      status_o,
  output logic [N-1:0]      mask_o,
  output logic              irq_o
);

  // set wins over a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else begin
      status_o <= (status_o & ~(clr_wr_i ? clr_i : '0)) | event_i;
    end
  end

  // mask register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mask_o <= '0;
    end else if (msk_wr_i) begin
      mask_o <= msk_i;
    end
  end

  // registered level output, updated at the same edge as status
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((status_o & ~(clr_wr_i ? clr_i : '0) | event_i) & mask_o);
    end
  end

endmodule

// >>> dv/fld_avs_master.sv
// model: avalon-mm master through which software reaches the decoder
`timescale 1ns/1ps
module fld_avs_master (
  // clock
  input  wire logic        clock_i,
  // slave answer
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  // request
  output logic [5:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o,
  output logic [3:0]       byteenable_o
);
  // idle values at time zero; all byte lanes always enabled
  initial begin
    address_o    = 6'h00;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0;
    byteenable_o = 4'hf;
  end
  // one transfer; held until waitrequest is low at a rising edge
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    address_o   <= a;
    writedata_o <= d;
    read_o      <= rd;
    write_o     <= !rd;
    // waitrequest is registered: the value read at an edge is the one that edge samples
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0) @(posedge clock_i);
    q = readdata_i;
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    address_o   <= ~a;  // released lines show no stale value
    writedata_o <= ~d;
  endtask
endmodule

// >>> dv/fld_leaf_decoder_asserts.sv
// checker: bus handshake and grant outcome of the leaf decoder
`timescale 1ns/1ps
module fld_leaf_decoder_asserts
  import fld_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = 48
) (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // bus and outcome
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        busy_o,
  input wire logic        granted_o
);
  logic [63:0] ent_reg;
  logic [7:0]  ctl_reg;
  logic [3:0]  req_reg;
  logic        usr, wrq, exq, cap, rsv, bad;
  // shadow of the programmed context; writes refused while busy left out
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctl_reg <= CTRL_RST[7:0];
    end else if (avs_write_i && !avs_waitrequest_o && !busy_o) begin
      case (avs_address_i[5:2])
        REG_CTRL:   ctl_reg <= avs_writedata_i[7:0];
        REG_ENT_LO: ent_reg[31:0] <= avs_writedata_i;
        REG_ENT_HI: ent_reg[63:32] <= avs_writedata_i;
        REG_REQ:    req_reg <= avs_writedata_i[3:0];
        default:    ;
      endcase
    end
  end
  // deny conditions of the request against the entry
  assign usr = req_reg[1] && !ent_reg[ENT_US_BIT];
  assign wrq = req_reg[3] && !ent_reg[ENT_RW_BIT] && (req_reg[1] || ctl_reg[CTL_WR_PROT]);
  assign exq = req_reg[2] && ctl_reg[CTL_NO_EXEC] && ent_reg[ENT_EXEC_DIS_BIT];
  assign cap = ctl_reg[CTL_CAP];
  assign rsv = (ent_reg[29:13] != '0) || (ent_reg[51:HOST_ADDR_WIDTH] != '0);
  assign bad = usr || wrq || exq || rsv || !ent_reg[ENT_P_BIT] || !ent_reg[ENT_SIZE_BIT] || !cap;
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_done;
    $fell(busy_o);
  endsequence
  property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than a cycle");
  property p_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_exec; s_done ##0 exq |-> !granted_o; endproperty
  a_exec: assert property (p_exec) else $error("exec granted");
  property p_user; s_done ##0 usr |-> !granted_o; endproperty
  a_user: assert property (p_user) else $error("user granted");
  property p_write; s_done ##0 wrq |-> !granted_o; endproperty
  a_write: assert property (p_write) else $error("write granted");
  property p_present; s_done ##0 !ent_reg[0] |-> !granted_o; endproperty
  a_present: assert property (p_present) else $error("absent granted");
  property p_leaf; s_done ##0 (cap && !ent_reg[7]) |-> !granted_o; endproperty
  a_leaf: assert property (p_leaf) else $error("directory granted");
  property p_cap; s_done ##0 (!cap && ent_reg[7]) |-> !granted_o; endproperty
  a_cap: assert property (p_cap) else $error("size bit accepted");
  property p_rsv; s_done ##0 rsv |-> !granted_o; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved accepted");
  property p_grant; s_done ##0 !bad |-> granted_o; endproperty
  a_grant: assert property (p_grant) else $error("clean entry denied");
  // busy stands for exactly the decode and done cycles
  property p_busy; $rose(busy_o) |=> busy_o ##1 !busy_o; endproperty
  a_busy: assert property (p_busy) else $error("decode not two cycles");
endmodule
bind fld_leaf_decoder fld_leaf_decoder_asserts #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o), .granted_o(granted_o));

// >>> dv/fld_leaf_decoder_test.sv
// testbench: table of entry decodes, then address, interrupt, map and reset checks
`timescale 1ns/1ps
module fld_leaf_decoder_test
  import fld_pkg::*;
;
  typedef struct packed {
    logic [63:0] ent;
    logic [7:0]  ctl;
    logic [3:0]  req;
    logic [15:0] msk;
    logic [15:0] exp;
  } fld_row_t;
  localparam logic [63:0] B = 64'h0000_8001_4000_0083;
  logic        clock, rst_n, rd_s, wr_s, wait_s, irq_s, busy_s, grant_s;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be;
  int          n_errors = 0;
  int          check_count = 0;
  localparam int PIN_GRANT = 0, PIN_IRQ = 1, PIN_BUSY = 2;
  // rows: entry, ctrl, request {wr,ex,user,coh}, result mask, expected result
  fld_row_t rows [19] = '{
    '{B, 8'h08, 4'h0, 16'h0003, 16'h0001},
    '{B | 64'h7ff0_0000_0000_0b00, 8'h08, 4'h8, 16'h0003, 16'h0003},
    '{B & ~64'h1, 8'h08, 4'h0, 16'h2001, 16'h2000},
    '{B & ~64'h80, 8'h08, 4'h0, 16'h0101, 16'h0100},
    '{B, 8'h00, 4'h0, 16'h1001, 16'h1000},
    '{B | 64'h2000, 8'h08, 4'h0, 16'h1001, 16'h1000},
    '{B | 64'h0001_0000_0000_0000, 8'h08, 4'h0, 16'h1001, 16'h1000},
    '{B, 8'h08, 4'h2, 16'h0801, 16'h0800},
    '{B ^ 64'h6, 8'h08, 4'ha, 16'h0401, 16'h0400},
    '{B & ~64'h2, 8'h0a, 4'h8, 16'h0401, 16'h0400},
    '{B & ~64'h2, 8'h08, 4'h8, 16'h0401, 16'h0001},
    '{B | 64'h8000_0000_0000_0000, 8'h09, 4'h4, 16'h0201, 16'h0200},
    '{B | 64'h8000_0000_0000_0000, 8'h08, 4'h4, 16'h0201, 16'h0001},
    '{B | 64'h1018, 8'h08, 4'h1, 16'h0071, 16'h0071},
    '{B | 64'h1018, 8'h08, 4'h0, 16'h0071, 16'h0001},
    '{B, 8'h0c, 4'h0, 16'h000f, 16'h000d},
    '{B, 8'h08, 4'h0, 16'h000d, 16'h0009},
    '{B, 8'h38, 4'h0, 16'h0081, 16'h0081},
    '{B, 8'h18, 4'h0, 16'h0081, 16'h0001}
  };
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  fld_avs_master m (.clock_i(clock), .readdata_i(rdata), .waitrequest_i(wait_s), .address_o(addr),
    .read_o(rd_s), .write_o(wr_s), .writedata_o(wdata), .byteenable_o(be));
  fld_leaf_decoder #(.HOST_ADDR_WIDTH(48)) dut (.clock_i(clock), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .irq_o(irq_s), .busy_o(busy_s), .granted_o(grant_s));
  // ****
  // helpers
  // ****
  function automatic logic [5:0] ba(input logic [3:0] w);
    return {w, 2'b00};
  endfunction
  task automatic wr(input logic [3:0] w, input logic [31:0] d);
    logic [31:0] x;
    m.xfer(1'b0, ba(w), d, x);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] msk, input logic [31:0] exp, input string s);
    check_count++;
    if ((got & msk) !== (exp & msk)) begin
      n_errors++;
      $display("unexpected at %0t: %s %h", $time, s, got);
    end
  endtask
  // flags are sampled at the falling edge, away from their update
  task automatic cmp_bit(input int pin, input logic exp, input string s);
    logic got;
    @(negedge clock);
    got = (pin == PIN_GRANT) ? grant_s : (pin == PIN_IRQ) ? irq_s : busy_s;
    cmp({31'h0, got}, 32'h1, {31'h0, exp}, s);
  endtask
  task automatic reg_is(input logic [5:0] a, input logic [31:0] msk, input logic [31:0] exp);
    m.xfer(1'b1, a, 32'h0, q);
    cmp(q, msk, exp, "register");
  endtask
  // program entry, context and request, start, poll until not busy
  task automatic dec(input fld_row_t r);
    int n;
    wr(REG_ENT_LO, r.ent[31:0]);
    wr(REG_ENT_HI, r.ent[63:32]);
    wr(REG_REQ, {28'h0, r.req});
    wr(REG_CTRL, {23'h0, 1'b1, r.ctl});
    n = 0;
    do begin
      m.xfer(1'b1, ba(REG_RES), 32'h0, q);
      n++;
    end while (q[14] !== 1'b0 && n < 20);
    cmp(q, 32'h4000, 32'h0, "decode stuck busy");
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #500000;
    n_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      dec(rows[i]);
      cmp(q, {16'h0, rows[i].msk} | 32'h4000, {16'h0, rows[i].exp}, "result");
      cmp_bit(PIN_GRANT, rows[i].exp[0], "grant pin");
      wr(REG_IRQ_ST, 32'h7);
    end
    // page base and write-back image of a granted write
    dec(rows[1]);
    reg_is(ba(REG_ADDR_LO), 32'hffff_ffff, 32'h4000_0000);
    reg_is(ba(REG_ADDR_HI), 32'hffff_ffff, 32'h0000_8001);
    reg_is(ba(REG_UPD_LO), 32'hffff_ffff, 32'h4000_0be3);
    // interrupt: unmasked done, clear, masked done, fault, nested
    wr(REG_IRQ_ST, 32'h7);
    wr(REG_IRQ_MSK, 32'h1);
    dec(rows[0]);
    cmp_bit(PIN_IRQ, 1'b1, "irq done");
    reg_is(ba(REG_IRQ_ST), 32'h7, 32'h1);
    wr(REG_IRQ_ST, 32'h1);
    repeat (2) @(posedge clock);
    cmp_bit(PIN_IRQ, 1'b0, "irq cleared");
    wr(REG_IRQ_MSK, 32'h2);
    dec(rows[0]);
    cmp_bit(PIN_IRQ, 1'b0, "irq masked");
    dec(rows[2]);
    cmp_bit(PIN_IRQ, 1'b1, "irq fault");
    reg_is(ba(REG_IRQ_ST), 32'h7, 32'h3);
    wr(REG_IRQ_ST, 32'h7);
    dec(rows[17]);
    reg_is(ba(REG_IRQ_ST), 32'h7, 32'h5);
    // unmapped words read zero
    reg_is(6'h2c, 32'hffff_ffff, 32'h0);
    reg_is(6'h3c, 32'hffff_ffff, 32'h0);
    // second reset in mid-run while the interrupt is raised
    wr(REG_IRQ_MSK, 32'h7);
    cmp_bit(PIN_IRQ, 1'b1, "irq before reset");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    cmp_bit(PIN_IRQ, 1'b0, "irq after reset");
    cmp_bit(PIN_BUSY, 1'b0, "busy after reset");
    reg_is(ba(REG_CTRL), 32'h1ff, CTRL_RST);
    reg_is(ba(REG_IRQ_ST), 32'h7, 32'h0);
    reg_is(ba(REG_IRQ_MSK), 32'h7, 32'h0);
    conclude();
  end
endmodule
